// ### core/spdrx_consts.vh
// Purpose: Constants for the receiver lock control and auxiliary TDM output
// Assumes: Registers are 1, 1 and 5 bits wide on a 16-bit bus and sit at their printed offsets
// Notes: Frame word layout is the buffer entry packing
`ifndef SPDRX_CONSTS_VH
`define SPDRX_CONSTS_VH

`define SPDRX_ADDR_W 16
`define SPDRX_DATA_W 16
`define SPDRX_OFS_RESUME 16'hF604
`define SPDRX_OFS_LOCKLOST 16'hF605
`define SPDRX_OFS_AUXCTRL 16'hF608
`define SPDRX_RST_RESUME 1'h0
`define SPDRX_RST_LOCKLOST 1'h0
`define SPDRX_RST_AUXCTRL 5'h00
`define SPDRX_AUXCTRL_W 5
`define SPDRX_SEL_MSB 3
`define SPDRX_SEL_P0 4'h1
`define SPDRX_SEL_P1 4'h2
`define SPDRX_SEL_P2 4'h4
`define SPDRX_SEL_P3 4'h8
`define SPDRX_PORTS 4

`define SPDRX_AUD_W 24
`define SPDRX_WORD_W 59
`define SPDRX_F_LAUD 58:35
`define SPDRX_F_RAUD 34:11
`define SPDRX_F_LPVUC 10:7
`define SPDRX_F_RPVUC 6:3
`define SPDRX_F_COMPR 2
`define SPDRX_F_ATYPE 1
`define SPDRX_F_BLK 0

`define SPDRX_CNT_W 8
`define SPDRX_SLOT_MSB 7
`define SPDRX_SLOT_LSB 5
`define SPDRX_BIT_MSB 4
`define SPDRX_SLOT_LAUD 3'h0
`define SPDRX_SLOT_LSTAT 3'h1
`define SPDRX_SLOT_TYPE 3'h2
`define SPDRX_SLOT_RAUD 3'h4
`define SPDRX_SLOT_RSTAT 3'h5
`define SPDRX_SLOT_BLK 3'h7

`endif

// ### core/spdrx_lock_aux.v
// Purpose: Lock-loss mute control and eight-slot TDM auxiliary output
// Assumes: Decoded subframe pairs and lock arrive on clk_i; TDM clocks are pins
// Notes: TDM bit clock and frame sync are sampled, data changes on falling bclk
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "spdrx_consts.vh"

module spdrx_lock_aux (
  input wire clk_i,
  input wire resetn_i,
  input wire [15:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire lock_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [23:0] in_left_i,
  input wire [23:0] in_right_i,
  input wire [3:0] in_left_pvuc_i,
  input wire [3:0] in_right_pvuc_i,
  input wire in_compr_type_i,
  input wire in_audio_type_i,
  input wire in_block_start_i,
  output wire audio_mute_o,
  input wire tdm_bclk_i,
  input wire tdm_fsync_i,
  output reg [3:0] serial_data_out_pin_o
);

  reg resume_q;
  reg lock_lost_sticky_q;
  reg [`SPDRX_AUXCTRL_W-1:0] aux_ctrl_q;
  reg muted_q;
  reg lock_prev_q;
  reg locked_once_q;

  wire wr_resume;
  wire lock_fall;
  wire lock_rise;
  wire clr_sticky;

  assign wr_resume = reg_wr_i && (reg_addr_i == `SPDRX_OFS_RESUME);
  assign lock_fall = lock_prev_q && !lock_i;
  assign lock_rise = !lock_prev_q && lock_i;
  // Writing 1 clears, and so does a relock while resume is enabled
  assign clr_sticky = (wr_resume && reg_wdata_i[0]) || (resume_q && lock_rise);

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      resume_q <= `SPDRX_RST_RESUME;
      aux_ctrl_q <= `SPDRX_RST_AUXCTRL;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `SPDRX_OFS_RESUME)
        resume_q <= reg_wdata_i[0];
      if (reg_addr_i == `SPDRX_OFS_AUXCTRL)
        aux_ctrl_q <= reg_wdata_i[`SPDRX_AUXCTRL_W-1:0];
    end
  end

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lock_prev_q <= 1'b0;
      locked_once_q <= 1'b0;
      lock_lost_sticky_q <= `SPDRX_RST_LOCKLOST;
      muted_q <= 1'b0;
    end
    else
    begin
      lock_prev_q <= lock_i;
      if (lock_i)
        locked_once_q <= 1'b1;
      // A loss in the same cycle as a clear keeps the flag set
      if (lock_fall && locked_once_q)
        lock_lost_sticky_q <= 1'b1;
      else if (clr_sticky)
        lock_lost_sticky_q <= 1'b0;
      if (lock_fall)
        muted_q <= 1'b1;
      else if (resume_q && lock_i)
        muted_q <= 1'b0;
    end
  end

  assign audio_mute_o = muted_q || !lock_i;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `SPDRX_OFS_RESUME: reg_rdata_o <= {15'h0000, resume_q};
        `SPDRX_OFS_LOCKLOST: reg_rdata_o <= {15'h0000, lock_lost_sticky_q};
        `SPDRX_OFS_AUXCTRL: reg_rdata_o <= {11'h000, aux_ctrl_q};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
    else
      reg_rdata_o <= 16'h0000;
  end

  // Two-entry buffer between the decoder and the TDM serializer
  reg [`SPDRX_WORD_W-1:0] buf_mem [0:1];
  reg buf_wp_q;
  reg buf_rp_q;
  reg [1:0] buf_cnt_q;
  wire buf_push;
  wire buf_pop;
  wire buf_empty;
  wire [`SPDRX_WORD_W-1:0] in_word;
  reg frame_start;

  assign in_word = {in_left_i, in_right_i, in_left_pvuc_i, in_right_pvuc_i,
                    in_compr_type_i, in_audio_type_i, in_block_start_i};
  assign in_ready_o = (buf_cnt_q != 2'h2);
  assign buf_empty = (buf_cnt_q == 2'h0);
  assign buf_push = in_valid_i && in_ready_o;
  assign buf_pop = frame_start && !buf_empty;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
      buf_cnt_q <= 2'h0;
    end
    else
    begin
      if (buf_push)
        buf_wp_q <= ~buf_wp_q;
      if (buf_pop)
        buf_rp_q <= ~buf_rp_q;
      if (buf_push && !buf_pop)
        buf_cnt_q <= buf_cnt_q + 2'h1;
      else if (buf_pop && !buf_push)
        buf_cnt_q <= buf_cnt_q - 2'h1;
    end
  end

  always @(posedge clk_i)
  begin
    if (buf_push)
      buf_mem[buf_wp_q] <= in_word;
  end

  // Three-stage samplers for the TDM clocks, change taken when stages agree
  reg [2:0] bclk_s_q;
  reg [2:0] fsync_s_q;
  reg bclk_q;
  reg fsync_q;
  reg fsync_at_fall_q;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bclk_s_q <= 3'h0;
      fsync_s_q <= 3'h0;
      bclk_q <= 1'b0;
      fsync_q <= 1'b0;
    end
    else
    begin
      bclk_s_q <= {bclk_s_q[1:0], tdm_bclk_i};
      fsync_s_q <= {fsync_s_q[1:0], tdm_fsync_i};
      if (bclk_s_q[1] == bclk_s_q[2])
        bclk_q <= bclk_s_q[2];
      if (fsync_s_q[1] == fsync_s_q[2])
        fsync_q <= fsync_s_q[2];
    end
  end

  wire bclk_fall;
  assign bclk_fall = bclk_q && (bclk_s_q[1] == bclk_s_q[2]) && !bclk_s_q[2];

  always @*
  begin
    frame_start = bclk_fall && fsync_q && !fsync_at_fall_q;
  end

  // Frame being sent and position within it
  reg [`SPDRX_WORD_W-1:0] cur_q;
  reg cur_mute_q;
  reg [`SPDRX_CNT_W-1:0] bit_cnt_q;
  wire [`SPDRX_CNT_W-1:0] next_cnt;
  wire [`SPDRX_WORD_W-1:0] next_word;

  assign next_cnt = frame_start ? {`SPDRX_CNT_W{1'b0}} : bit_cnt_q + 8'h01;
  // An empty buffer sends an all-zero frame rather than stale data
  assign next_word = frame_start ? (buf_empty ? {`SPDRX_WORD_W{1'b0}} : buf_mem[buf_rp_q])
                                 : cur_q;

  function [31:0] slot_word;
    input [2:0] slot;
    input [`SPDRX_WORD_W-1:0] w;
    input mute;
    reg [23:0] la;
    reg [23:0] ra;
    begin
      la = mute ? 24'h000000 : w[`SPDRX_F_LAUD];
      ra = mute ? 24'h000000 : w[`SPDRX_F_RAUD];
      case (slot)
        `SPDRX_SLOT_LAUD: slot_word = {la, 8'h00};
        `SPDRX_SLOT_LSTAT: slot_word = {20'h00000, w[`SPDRX_F_LPVUC], 8'h00};
        `SPDRX_SLOT_TYPE: slot_word = {22'h000000, w[`SPDRX_F_COMPR],
                                       w[`SPDRX_F_ATYPE], 8'h00};
        `SPDRX_SLOT_RAUD: slot_word = {ra, 8'h00};
        `SPDRX_SLOT_RSTAT: slot_word = {20'h00000, w[`SPDRX_F_RPVUC], 8'h00};
        `SPDRX_SLOT_BLK: slot_word = {23'h000000, w[`SPDRX_F_BLK], 8'h00};
        default: slot_word = 32'h00000000;
      endcase
    end
  endfunction

  wire [31:0] next_slot;
  wire next_bit;
  wire next_mute;
  assign next_mute = frame_start ? audio_mute_o : cur_mute_q;
  assign next_slot = slot_word(next_cnt[`SPDRX_SLOT_MSB:`SPDRX_SLOT_LSB], next_word, next_mute);
  assign next_bit = next_slot[5'h1F - next_cnt[`SPDRX_BIT_MSB:0]];

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fsync_at_fall_q <= 1'b0;
      bit_cnt_q <= {`SPDRX_CNT_W{1'b0}};
      cur_q <= {`SPDRX_WORD_W{1'b0}};
      cur_mute_q <= 1'b1;
    end
    else if (bclk_fall)
    begin
      fsync_at_fall_q <= fsync_q;
      bit_cnt_q <= next_cnt;
      cur_q <= next_word;
      cur_mute_q <= next_mute;
    end
  end

  // One-hot select in aux_ctrl_q[3:0], bit 4 ignored; any other value of those four bits keeps all ports quiet
  genvar gi;
  generate
    for (gi = 0; gi < `SPDRX_PORTS; gi = gi + 1)
    begin : g_port
      wire sel;
      assign sel = (aux_ctrl_q[`SPDRX_SEL_MSB:0] == (4'h1 << gi));
      always @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          serial_data_out_pin_o[gi] <= 1'b0;
        else if (!sel)
          serial_data_out_pin_o[gi] <= 1'b0;
        else if (bclk_fall)
          serial_data_out_pin_o[gi] <= next_bit;
      end
    end
  endgenerate

endmodule // spdrx_lock_aux

// ### tb/spdrx_lock_aux_checker.sv
// Purpose: Port checks of mute, reads and port select
// Assumes: One clock domain
// Notes: Resume bit mirrored from bus writes
`timescale 1ns/100ps
module spdrx_lock_aux_checker (
  input wire clk_i,
  input wire resetn_i,
  input wire [15:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire lock_i,
  input wire audio_mute_o,
  input wire [3:0] serial_data_out_pin_o
);
  logic res_q;
  wire res_wr = reg_wr_i && reg_addr_i == 16'hF604;
  wire rd_map = reg_addr_i == 16'hF604 || reg_addr_i == 16'hF605 || reg_addr_i == 16'hF608;
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      res_q <= 1'b0;
    else if (res_wr)
      res_q <= reg_wdata_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_MUTE_NOLOCK: assert property (!lock_i |-> audio_mute_o)
    else $error("unmuted without lock");
  AST_MUTE_FALL: assert property ($fell(lock_i) |=> audio_mute_o)
    else $error("no mute after loss");
  AST_NO_AUTO: assert property (audio_mute_o && lock_i && !res_q && !res_wr |=> audio_mute_o)
    else $error("resumed on its own");
  AST_AUTO: assert property ((res_q && lock_i)[*3] |-> !audio_mute_o)
    else $error("no auto resume");
  AST_RD_UNMAP: assert property (reg_rd_i && !rd_map |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_RD_RESUME: assert property (reg_rd_i && res_wr == 0 && reg_addr_i == 16'hF604
    |=> reg_rdata_o == {15'h0000, $past(res_q)})
    else $error("resume readback");
  AST_STICKY_CLR: assert property (res_wr && reg_wdata_i[0] && lock_i ##1 lock_i
    ##1 (lock_i && reg_rd_i && reg_addr_i == 16'hF605) |=> reg_rdata_o == 16'h0000)
    else $error("sticky not cleared");
  AST_SEL_ONEHOT: assert property ($onehot0(serial_data_out_pin_o))
    else $error("several ports driven");
  COV_FALL: cover property ($fell(lock_i));
  COV_CLR: cover property (res_wr && reg_wdata_i[0]);
  COV_OUT: cover property (|serial_data_out_pin_o);
endmodule // spdrx_lock_aux_checker
bind spdrx_lock_aux spdrx_lock_aux_checker chk (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .lock_i, .audio_mute_o, .serial_data_out_pin_o);

// ### tb/spdrx_tdm_partner.sv
// Purpose: Far TDM receiver, also bit clock and sync source
// Assumes: 256 bit clocks a frame, sync high over bit 0
// Notes: Samples on falling bclk, one bit behind launch
`timescale 1ns/100ps
module spdrx_tdm_partner (
  output logic bclk_o,
  output logic fsync_o,
  input wire logic [3:0] sdo_i,
  input wire logic [1:0] port_i,
  output logic [255:0] frame_o,
  output int frames_o
);
  logic [255:0] sh;
  int n;
  initial
  begin
    bclk_o = 0;
    fsync_o = 0;
    sh = '0;
    frame_o = '0;
    frames_o = 0;
    n = 0;
    #13;
    forever
    begin
      #200 bclk_o = 1;
      n = (n + 1) % 256;
      fsync_o = (n == 0);
      #200 bclk_o = 0;
      sh = {sh[254:0], sdo_i[port_i]};
      if (n == 0)
      begin
        frame_o = sh;
        frames_o++;
      end
    end
  end
endmodule // spdrx_tdm_partner

// ### tb/tb_spdrx_lock_aux.sv
// Purpose: Bench for lock mute and auxiliary TDM output
// Assumes: Partner drives bit clock and frame sync
// Notes: Whole frames compared against the slot layout
`timescale 1ns/100ps
module tb_spdrx_lock_aux;
  logic clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, lock_i = 0, in_valid_i = 0;
  logic [15:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o;
  logic [58:0] w_i = '0;
  logic [3:0] sdo, p;
  logic in_ready_o, audio_mute_o, bclk, fsync;
  logic [255:0] frame;
  int frames, n, errors = 0, cmp_count = 0;
  spdrx_lock_aux uut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lock_i(lock_i), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .in_left_i(w_i[58:35]), .in_right_i(w_i[34:11]),
    .in_left_pvuc_i(w_i[10:7]), .in_right_pvuc_i(w_i[6:3]), .in_compr_type_i(w_i[2]),
    .in_audio_type_i(w_i[1]), .in_block_start_i(w_i[0]), .audio_mute_o(audio_mute_o),
    .tdm_bclk_i(bclk), .tdm_fsync_i(fsync), .serial_data_out_pin_o(sdo));
  spdrx_tdm_partner far (.bclk_o(bclk), .fsync_o(fsync), .sdo_i(sdo), .port_i(p[1:0]),
    .frame_o(frame), .frames_o(frames));
  function logic [58:0] mk(input logic [3:0] q, input logic k);
    return {4'hA, q, 15'h5C00, k, 4'h3, q, 16'hC96A, q ^ 4'h9, q ^ 4'h6, k, q[0], ~k};
  endfunction
  function logic [255:0] ex(input logic [58:0] w);
    return {w[58:35], 8'h00, 20'h00000, w[10:7], 8'h00, 22'h000000, w[2], w[1], 8'h00,
      32'h00000000, w[34:11], 8'h00, 20'h00000, w[6:3], 8'h00, 32'h00000000, 23'h000000,
      w[0], 8'h00};
  endfunction
  task complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [255:0] g, input logic [255:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 chk(reg_rdata_o, e);
  endtask
  task lock(input logic v);
    @(posedge clk_i);
    lock_i <= v;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task push(input logic [58:0] w);
    @(posedge clk_i);
    w_i <= w;
    in_valid_i <= 1;
    @(posedge clk_i);
    in_valid_i <= 0;
    #1;
  endtask
  task wait_frame;
    n = frames;
    wait (frames != n);
  endtask
  initial
    forever #25 clk_i = ~clk_i;
  initial
  begin
    #3000000;
    errors++;
    complete_run;
  end
  initial
  begin
    p = 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1;
    rd(16'hF604, 16'h0000);
    rd(16'hF605, 16'h0000);
    wr(16'hF608, 16'hFFE8);
    rd(16'hF608, 16'h0008);
    rd(16'hF606, 16'h0000);
    lock(1);
    chk(audio_mute_o, 0);
    rd(16'hF605, 16'h0000);
    lock(0);
    chk(audio_mute_o, 1);
    rd(16'hF605, 16'h0001);
    lock(1);
    chk(audio_mute_o, 1);
    rd(16'hF605, 16'h0001);
    wr(16'hF604, 16'h0001);
    rd(16'hF605, 16'h0000);
    wr(16'hF604, 16'hFFFE);
    rd(16'hF604, 16'h0000);
    chk(audio_mute_o, 0);
    wr(16'hF604, 16'h0001);
    lock(0);
    rd(16'hF605, 16'h0001);
    lock(1);
    rd(16'hF605, 16'h0000);
    chk(audio_mute_o, 0);
    for (p = 0; p < 4; p++)
    begin
      wr(16'hF608, 16'h0001 << p);
      wait_frame;
      repeat (10) @(posedge clk_i);
      push(mk(p, 0));
      push(mk(p, 1));
      chk(in_ready_o, 0);
      wait_frame;
      wait_frame;
      chk(frame, ex(mk(p, 0)));
      wait_frame;
      chk(frame, ex(mk(p, 1)));
    end
    // Lock lost: the next frame keeps its status slots but carries silent audio
    p = 3;
    lock(0);
    repeat (10) @(posedge clk_i);
    push(mk(3, 1));
    wait_frame;
    wait_frame;
    chk(frame, ex(mk(3, 1) & 59'h000000000007FF));
    complete_run;
  end
endmodule // tb_spdrx_lock_aux
